// [dv/eeprom_slave_model.sv]
// Behavioural serial EEPROM slave on the open-drain two-wire bus.
`timescale 1ns/100ps
module eeprom_slave_model (
	input wire logic scl,
	input wire logic sda,
	input wire logic nack_all,
	output logic sda_rel
);
	logic [7:0] mem [256];
	logic [7:0] rx_log [$];
	logic [7:0] sh, ptr, dout;
	logic [3:0] cnt;
	logic [2:0] md, nm;
	initial begin
		sda_rel = 1'b1;
		md = 3'h0;
		nm = 3'h0;
		cnt = 4'h0;
		ptr = 8'h00;
	end
	////////////////////////////////////////
	// Mode 1 address, 2 word pointer, 3 write data, 4 read data
	task automatic ack_byte();
		logic ok;
		ok = !nack_all && (md != 3'h1 || sh[7:1] == 7'h50);
		sda_rel = !ok;
		rx_log.push_back(sh);
		if (!ok)
			nm = 3'h0;
		else if (md == 3'h1)
			nm = sh[0] ? 3'h4 : 3'h2;
		else if (md == 3'h2)
			nm = 3'h3;
		if (ok && md == 3'h2)
			ptr = sh;
		if (ok && md == 3'h3) begin
			mem[ptr] = sh;
			ptr = ptr + 8'h01;
		end
		if (ok && nm == 3'h4)
			dout = mem[ptr];
	endtask
	// Any SDA edge with SCL high is a start or a stop
	always @(sda) begin
		if (scl === 1'b1) begin
			md = sda ? 3'h0 : 3'h1;
			nm = md;
			cnt = 4'h0;
		end
	end
	always @(posedge scl) begin
		if (md != 3'h0) begin
			sh = {sh[6:0], sda};
			if (md == 3'h4 && cnt == 4'h8) begin
				nm = sda ? 3'h0 : 3'h4;
				ptr = sda ? ptr : ptr + 8'h01;
				dout = mem[ptr];
			end
			cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
		end
	end
	// Data only moves while SCL is low, as a real slave would
	always @(negedge scl) begin
		if (cnt == 4'h0)
			md = nm;
		if (md == 3'h4)
			sda_rel = (cnt < 4'h8) ? dout[3'h7 - cnt[2:0]] : 1'b1;
		else if (md != 3'h0 && cnt == 4'h8)
			ack_byte();
		else
			sda_rel = 1'b1;
	end
endmodule

// [dv/test_i2c_master_eeprom_upload.sv]
// Self-checking bench for the serial bus master and identity upload.
`timescale 1ns/100ps
module test_i2c_master_eeprom_upload;
	logic clk, rst, reg_wr, reg_rd, cfg_wr, cfg_rd, we, nack_all, sda_rel, retry;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, cfg_wdata, cfg_rdata, rd;
	logic [7:0] cfg_addr;
	logic cfg_retry, scl_oe_n, sda_oe_n, irq, busy;
	int fails, check_count;
	realtime t_last, period;
	// Pull-ups: a released line reads high
	wire scl_w = (scl_oe_n !== 1'b0);
	wire sda_w = (sda_oe_n !== 1'b0) & sda_rel;
	i2c_master_eeprom_upload dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.cfg_retry(cfg_retry), .subsys_id_write_enable(we), .scl_i(scl_w), .scl_o(),
		.scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(), .sda_oe_n(sda_oe_n),
		.transfer_done_irq(irq), .busy(busy));
	eeprom_slave_model slave (.scl(scl_w), .sda(sda_w), .nack_all(nack_all), .sda_rel(sda_rel));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge scl_w) begin
		period = $realtime - t_last;
		t_last = $realtime;
	end
	////////////////////////////////////////
	task automatic report_and_stop();
		$display("Counts: %0d checks, %0d mismatches", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask
	// Last SCL period must lie within four quarter ticks of q or q+1 cycles
	task automatic chk_period(input int q);
		check_count++;
		if (period < 16.0 * q || period > 16.0 * (q + 1)) begin
			fails++;
			$display("ERROR %0t clock period %0.1f ns", $time, period);
		end
	endtask
	task automatic step();
		@(posedge clk);
		#1;
	endtask
	task automatic reg_write(input logic [31:0] d);
		step();
		reg_wr = 1'b1;
		reg_addr = 12'h110;
		reg_wdata = d;
		step();
		reg_wr = 1'b0;
	endtask
	task automatic reg_read(input logic [11:0] a);
		step();
		reg_rd = 1'b1;
		reg_addr = a;
		step();
		reg_rd = 1'b0;
		rd = reg_rdata;
	endtask
	task automatic cfg_acc(input logic wr, input logic [31:0] d);
		step();
		cfg_wr = wr;
		cfg_rd = !wr;
		cfg_wdata = d;
		#1;
		retry = cfg_retry;
		step();
		{cfg_wr, cfg_rd} = 2'b00;
		rd = cfg_rdata;
	endtask
	task automatic wait_idle(input int lim);
		int n;
		n = 0;
		while (busy !== 1'b0 && n < lim) begin
			step();
			n++;
		end
		chk({31'h0, busy}, 32'h0, "finished in time");
	endtask
	task automatic xfer(input logic [31:0] d);
		reg_write(d);
		wait_idle(80000);
		chk({31'h0, irq}, 32'h1, "done flag");
	endtask
	task automatic do_reset();
		rst = 1'b1;
		repeat (3) step();
		slave.rx_log.delete();
		rst = 1'b0;
	endtask
	task automatic rx_byte(input logic [7:0] exp);
		reg_read(12'h110);
		chk({24'h0, rd[15:8]}, {24'h0, exp}, "received byte");
	endtask
	function automatic logic [31:0] log3();
		return {slave.rx_log[0], slave.rx_log[1], slave.rx_log[2], 8'h00};
	endfunction
	////////////////////////////////////////
	task automatic t_abort();
		nack_all = 1'b1;
		do_reset();
		cfg_acc(1'b0, 32'h0);
		chk({31'h0, retry}, 32'h1, "retry while uploading");
		wait_idle(40000);
		cfg_acc(1'b0, 32'h0);
		chk({31'h0, retry}, 32'h0, "no retry after abort");
		chk(rd, 32'h0, "identity after abort");
		chk(32'(slave.rx_log.size()), 32'h1, "abort at first byte");
		chk({24'h0, slave.rx_log[0]}, 32'ha0, "slave address");
		$display("test upload_abort done");
	endtask
	task automatic t_upload();
		nack_all = 1'b0;
		slave.mem[8'hfc] = 8'h11;
		slave.mem[8'hfd] = 8'h22;
		slave.mem[8'hfe] = 8'h33;
		slave.mem[8'hff] = 8'h44;
		do_reset();
		reg_write(32'ha0010290);
		chk({31'h0, busy}, 32'h1, "busy in upload");
		wait_idle(200000);
		chk_period(i2c_pkg::Q_UPL);
		chk(log3(), 32'ha0fca100, "upload header");
		chk(32'(slave.rx_log.size()), 32'h3, "refused write");
		chk({31'h0, irq}, 32'h0, "upload raises no done");
		cfg_acc(1'b0, 32'h0);
		chk(rd, 32'h11223344, "identity order");
		cfg_acc(1'b1, 32'hdeadbeef);
		cfg_acc(1'b0, 32'h0);
		chk(rd, 32'h11223344, "identity read-only");
		we = 1'b1;
		cfg_acc(1'b1, 32'h5a5aa5a5);
		we = 1'b0;
		cfg_acc(1'b0, 32'h0);
		chk(rd, 32'h5a5aa5a5, "identity written");
		$display("test upload done");
	endtask
	task automatic t_write();
		// The upload leaves its own header bytes in the log
		slave.rx_log.delete();
		slave.mem[8'h06] = 8'h66;
		xfer(32'ha0055a90);
		chk(log3(), 32'ha0055a00, "three byte write");
		chk({24'h0, slave.mem[8'h05]}, 32'h5a, "written byte");
		chk_period(i2c_pkg::Q_FAST);
		reg_read(12'h110);
		chk({31'h0, rd[2]}, 32'h1, "all acks seen");
		slave.rx_log.delete();
		xfer(32'ha0067780);
		chk(32'(slave.rx_log.size()), 32'h2, "two byte write");
		chk({24'h0, slave.mem[8'h06]}, 32'h66, "third byte not sent");
		$display("test write done");
	endtask
	task automatic t_random_read();
		slave.rx_log.delete();
		xfer(32'ha00500c0);
		repeat (4 * i2c_pkg::Q_FAST) step();
		chk({30'h0, scl_w, busy}, 32'h0, "clock held low");
		xfer(32'ha1000000);
		chk(log3(), 32'ha005a100, "repeated start");
		chk_period(i2c_pkg::Q_SLOW);
		rx_byte(8'h5a);
		chk({30'h0, sda_w, scl_w}, 32'h3, "bus released");
		$display("test random_read done");
	endtask
	task automatic t_sequential();
		slave.mem[8'h22] = 8'h99;
		xfer(32'ha02000c0);
		xfer(32'h770000e0);
		xfer(32'h880000a0);
		chk({slave.mem[8'h20], slave.mem[8'h21]}, 32'h7788, "chained write");
		xfer(32'ha02000c0);
		xfer(32'ha10000d0);
		rx_byte(8'h77);
		xfer(32'h000000f0);
		rx_byte(8'h88);
		xfer(32'h000000a0);
		rx_byte(8'h99);
		chk({30'h0, sda_w, scl_w}, 32'h3, "stop after nack");
		$display("test sequential done");
	endtask
	task automatic t_nack_and_soft();
		xfer(32'hb0000090);
		reg_read(12'h110);
		chk({31'h0, rd[2]}, 32'h0, "missing ack");
		reg_read(12'h114);
		chk(rd, 32'h0, "unmapped read");
		reg_write(32'h00000009);
		repeat (4) step();
		chk({30'h0, sda_w, scl_w}, 32'h1, "software drive");
		reg_read(12'h110);
		chk({30'h0, rd[1:0]}, 32'h1, "pin readback");
		reg_write(32'h0000000b);
		repeat (4) step();
		chk({30'h0, sda_w, scl_w}, 32'h3, "software release");
		$display("test nack_and_soft done");
	endtask
	////////////////////////////////////////
	initial begin
		#4_000_000;
		fails++;
		$display("ERROR %0t watchdog expired", $time);
		report_and_stop();
	end
	initial begin
		{reg_wr, reg_rd, cfg_wr, cfg_rd, we, nack_all} = 6'h00;
		rst = 1'b1;
		reg_addr = 12'h110;
		reg_wdata = 32'h0;
		cfg_addr = 8'h2c;
		cfg_wdata = 32'h0;
		fails = 0;
		check_count = 0;
		t_last = 0;
		period = 0;
		t_abort();
		t_upload();
		t_write();
		t_random_read();
		t_sequential();
		t_nack_and_soft();
		report_and_stop();
	end
endmodule

// [hw/i2c_master_eeprom_upload.sv]
// Register driven serial bus master with identity upload from EEPROM after reset.
`timescale 1ns/100ps
module i2c_master_eeprom_upload (
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_retry,
	input wire logic subsys_id_write_enable,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_n,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	output logic transfer_done_irq,
	output logic busy
);
	////////////////////////////////////////////////////////////////////////////
	function automatic i2c_pkg::op_t plan(i2c_pkg::kind_t k, logic [3:0] s,
			logic three, logic rdir, logic ack);
		i2c_pkg::op_t rx;
		rx = ack ? i2c_pkg::OP_RXA : i2c_pkg::OP_RXN;
		case (k)
			i2c_pkg::K_WR: begin
				if (s == 4'h0) return i2c_pkg::OP_START;
				if (s == 4'h1 || s == 4'h2) return i2c_pkg::OP_TX;
				if (s == 4'h3 && three) return i2c_pkg::OP_TX;
				return i2c_pkg::OP_END;
			end
			i2c_pkg::K_RD: begin
				if (s == 4'h0) return i2c_pkg::OP_START;
				if (s == 4'h1) return i2c_pkg::OP_TX;
				if (s == 4'h2) return rx;
				return i2c_pkg::OP_END;
			end
			i2c_pkg::K_CONT: begin
				if (s == 4'h0) return rdir ? rx : i2c_pkg::OP_TX;
				return i2c_pkg::OP_END;
			end
			default: begin
				if (s == 4'h0 || s == 4'h3) return i2c_pkg::OP_START;
				if (s == 4'h1 || s == 4'h2 || s == 4'h4) return i2c_pkg::OP_TX;
				if (s >= 4'h5 && s <= 4'h7) return i2c_pkg::OP_RXA;
				if (s == 4'h8) return i2c_pkg::OP_RXN;
				return i2c_pkg::OP_END;
			end
		endcase
	endfunction

	function automatic logic [7:0] phys_addr(logic [7:0] logical);
		return ~(logical + i2c_pkg::LOGICAL_BIAS);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	logic scl_m_r, scl_s_r, sda_m_r, sda_s_r;
	logic [7:0] b0_r, b1_r, b2_r;
	logic speed_r, nostop_r, nos1b_r, w3bra_r, sw_mode_r, sw_scl_r, sw_sda_r;
	i2c_pkg::state_t state_r, state_nxt;
	i2c_pkg::kind_t kind_r, kind_nxt;
	logic [3:0] seq_r, seq_nxt, bit_r, bit_nxt;
	logic [1:0] q_r, q_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic dir_r, dir_nxt, ack_ok_r, ackok_nxt, done_r, done_nxt;
	logic scl_hw_r, scl_nxt, sda_hw_r, sda_nxt;
	logic upl_pend_r, pend_nxt, upl_done_r, upld_nxt;
	logic [31:0] upl_buf_r, buf_nxt, ssid_r;
	logic rx_load, ssid_load, tick;
	logic [i2c_pkg::QW-1:0] qlim;

	// Pins are sampled through two flops before the engine looks at them
	always_ff @(posedge clk) begin
		if (rst) begin
			{scl_m_r, scl_s_r, sda_m_r, sda_s_r} <= 4'hf;
		end else begin
			{scl_m_r, scl_s_r} <= {scl_i, scl_m_r};
			{sda_m_r, sda_s_r} <= {sda_i, sda_m_r};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	wire ctrl_hit = (reg_addr == i2c_pkg::CTRL_OFF);
	assign busy = upl_pend_r
		|| (state_r != i2c_pkg::ST_IDLE && state_r != i2c_pkg::ST_HOLD);
	wire accept = reg_wr && ctrl_hit && !busy;
	wire [7:0] w_b0 = reg_wdata[i2c_pkg::B0_LSB +: 8];
	wire w_nos1b = reg_wdata[i2c_pkg::NOS1B_BIT];
	wire w_swmode = reg_wdata[i2c_pkg::SWMODE_BIT];
	wire launch = accept && !w_swmode;
	wire [31:0] ctrl_rd = {b0_r, b1_r, b2_r, speed_r, nostop_r, nos1b_r,
		w3bra_r, sw_mode_r, ack_ok_r, sda_s_r, scl_s_r};

	always_ff @(posedge clk) begin
		if (rst) begin
			{b0_r, b1_r} <= {i2c_pkg::BYTE_RST, i2c_pkg::BYTE_RST};
			b2_r <= i2c_pkg::BYTE_RST;
			{speed_r, nostop_r, nos1b_r, w3bra_r} <= 4'h0;
			{sw_mode_r, sw_scl_r, sw_sda_r} <= 3'h3;
			reg_rdata <= '0;
		end else begin
			if (accept) begin
				b0_r <= w_b0;
				b1_r <= reg_wdata[i2c_pkg::B1_LSB +: 8];
				b2_r <= reg_wdata[i2c_pkg::B2_LSB +: 8];
				speed_r <= reg_wdata[i2c_pkg::SPEED_BIT];
				nostop_r <= reg_wdata[i2c_pkg::NOSTOP_BIT];
				nos1b_r <= w_nos1b;
				w3bra_r <= reg_wdata[i2c_pkg::W3BRA_BIT];
				sw_mode_r <= w_swmode;
				sw_scl_r <= reg_wdata[i2c_pkg::SCL_BIT];
				sw_sda_r <= reg_wdata[i2c_pkg::SDA_BIT];
			end
			if (rx_load) b2_r <= sh_r;
			reg_rdata <= (reg_rd && ctrl_hit) ? ctrl_rd : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Rate choice per transfer
	assign qlim = (kind_r == i2c_pkg::K_UPL) ? i2c_pkg::Q_UPL
		: speed_r ? i2c_pkg::Q_FAST : i2c_pkg::Q_SLOW;

	quarter_tick #(.W(i2c_pkg::QW)) u_tick (
		.clk(clk),
		.rst(rst),
		.limit(qlim),
		.tick(tick)
	);

	// Direction kept from the last start
	wire i2c_pkg::op_t cur_op = plan(kind_r, seq_r, w3bra_r, dir_r, w3bra_r);
	wire rx = (cur_op == i2c_pkg::OP_RXA) || (cur_op == i2c_pkg::OP_RXN);
	wire bit8 = (bit_r == i2c_pkg::BITS_PER_BYTE);
	wire [7:0] ee_wr = {i2c_pkg::EEPROM_ADDR7, 1'b0};
	wire [7:0] ee_rd = {i2c_pkg::EEPROM_ADDR7, 1'b1};
	wire [7:0] upl_byte = (seq_r == 4'h1) ? ee_wr
		: (seq_r == 4'h2) ? phys_addr(i2c_pkg::UPL_LOGICAL) : ee_rd;
	wire [7:0] hw_byte = (seq_r == 4'h2) ? b1_r : (seq_r == 4'h3) ? b2_r : b0_r;
	wire [7:0] tx_byte = (kind_r == i2c_pkg::K_UPL) ? upl_byte : hw_byte;

	always_comb begin
		state_nxt = state_r;
		kind_nxt = kind_r;
		seq_nxt = seq_r;
		q_nxt = q_r;
		bit_nxt = bit_r;
		sh_nxt = sh_r;
		dir_nxt = dir_r;
		ackok_nxt = ack_ok_r;
		done_nxt = done_r;
		scl_nxt = scl_hw_r;
		sda_nxt = sda_hw_r;
		pend_nxt = upl_pend_r;
		upld_nxt = upl_done_r;
		buf_nxt = upl_buf_r;
		rx_load = 1'b0;
		ssid_load = 1'b0;
		if (accept) done_nxt = 1'b0;
		// Kind picked from the new fields
		if (launch) begin
			state_nxt = i2c_pkg::ST_NEXT;
			seq_nxt = 4'h0;
			ackok_nxt = 1'b1;
			kind_nxt = w_nos1b ? i2c_pkg::K_CONT : w_b0[0] ? i2c_pkg::K_RD : i2c_pkg::K_WR;
		end
		// Upload takes the bus first after reset
		if (upl_pend_r && state_r == i2c_pkg::ST_IDLE) begin
			state_nxt = i2c_pkg::ST_NEXT;
			kind_nxt = i2c_pkg::K_UPL;
			seq_nxt = 4'h0;
			ackok_nxt = 1'b1;
		end
		case (state_r)
			i2c_pkg::ST_NEXT: begin
				q_nxt = 2'h0;
				bit_nxt = 4'h0;
				case (cur_op)
					i2c_pkg::OP_START: state_nxt = i2c_pkg::ST_START;
					i2c_pkg::OP_TX: begin
						state_nxt = i2c_pkg::ST_BIT;
						sh_nxt = tx_byte;
					end
					i2c_pkg::OP_RXA, i2c_pkg::OP_RXN: state_nxt = i2c_pkg::ST_BIT;
					default: begin
						// Park with SCL low instead of stopping
						if (nostop_r && kind_r != i2c_pkg::K_UPL) begin
							state_nxt = i2c_pkg::ST_HOLD;
							done_nxt = 1'b1;
						end else begin
							state_nxt = i2c_pkg::ST_STOP;
						end
					end
				endcase
			end
			i2c_pkg::ST_START: begin
				// SDA falls while SCL is high
				if (tick) begin
					q_nxt = q_r + 2'h1;
					case (q_r)
						2'h0: sda_nxt = 1'b1;
						2'h1: scl_nxt = 1'b1;
						2'h2: sda_nxt = 1'b0;
						default: begin
							scl_nxt = 1'b0;
							if (kind_r != i2c_pkg::K_UPL) dir_nxt = b0_r[0];
							seq_nxt = seq_r + 4'h1;
							state_nxt = i2c_pkg::ST_NEXT;
						end
					endcase
				end
			end
			i2c_pkg::ST_BIT: begin
				if (tick) begin
					q_nxt = q_r + 2'h1;
					case (q_r)
						// Data moves only in the low phase
						// Master ack or nack on the ninth bit
						2'h0: sda_nxt = bit8 ? (rx ? (cur_op == i2c_pkg::OP_RXN) : 1'b1)
							: (rx ? 1'b1 : sh_r[7]);
						2'h1: scl_nxt = 1'b1;
						2'h2: if (!bit8) sh_nxt = {sh_r[6:0], sda_s_r};
						default: begin
							scl_nxt = 1'b0;
							if (!bit8) begin
								bit_nxt = bit_r + 4'h1;
							end else if (rx) begin
								seq_nxt = seq_r + 4'h1;
								state_nxt = i2c_pkg::ST_NEXT;
								// First byte ends at the top
								if (kind_r == i2c_pkg::K_UPL) buf_nxt = {upl_buf_r[23:0], sh_r};
								else rx_load = 1'b1;
							end else if (sda_s_r) begin
								// Missing ack aborts with a stop
								ackok_nxt = 1'b0;
								state_nxt = i2c_pkg::ST_STOP;
							end else begin
								seq_nxt = seq_r + 4'h1;
								state_nxt = i2c_pkg::ST_NEXT;
							end
						end
					endcase
				end
			end
			i2c_pkg::ST_STOP: begin
				// SDA rises while SCL is high
				if (tick) begin
					q_nxt = q_r + 2'h1;
					case (q_r)
						2'h0: sda_nxt = 1'b0;
						2'h1: scl_nxt = 1'b1;
						2'h2: sda_nxt = 1'b1;
						default: begin
							state_nxt = i2c_pkg::ST_IDLE;
							if (kind_r == i2c_pkg::K_UPL) begin
								pend_nxt = 1'b0;
								upld_nxt = 1'b1;
								ssid_load = ack_ok_r;
							end else begin
								done_nxt = 1'b1;
							end
						end
					endcase
				end
			end
			default: ;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= i2c_pkg::ST_IDLE;
			kind_r <= i2c_pkg::K_WR;
			{seq_r, bit_r, q_r} <= 10'h000;
			sh_r <= i2c_pkg::BYTE_RST;
			{dir_r, ack_ok_r, done_r} <= 3'h0;
			{scl_hw_r, sda_hw_r} <= 2'h3;
			{upl_pend_r, upl_done_r} <= 2'h2;
			upl_buf_r <= i2c_pkg::SSID_RST;
		end else begin
			state_r <= state_nxt;
			kind_r <= kind_nxt;
			{seq_r, bit_r, q_r} <= {seq_nxt, bit_nxt, q_nxt};
			sh_r <= sh_nxt;
			{dir_r, ack_ok_r, done_r} <= {dir_nxt, ackok_nxt, done_nxt};
			{scl_hw_r, sda_hw_r} <= {scl_nxt, sda_nxt};
			{upl_pend_r, upl_done_r} <= {pend_nxt, upld_nxt};
			upl_buf_r <= buf_nxt;
		end
	end
	assign transfer_done_irq = done_r;

	////////////////////////////////////////////////////////////////////////////
	// Software owns the pins in bit-bang mode
	wire scl_lvl = sw_mode_r ? sw_scl_r : scl_hw_r;
	wire sda_lvl = sw_mode_r ? sw_sda_r : sda_hw_r;

	// Open drain: only ever pull low, release otherwise
	always_ff @(posedge clk) begin
		if (rst) begin
			{scl_oe_n, sda_oe_n} <= 2'h3;
		end else begin
			scl_oe_n <= scl_lvl;
			sda_oe_n <= sda_lvl;
		end
	end
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	wire cfg_hit = (cfg_addr == i2c_pkg::SSID_OFF);
	// Retry until the upload is over
	assign cfg_retry = (cfg_rd || cfg_wr) && cfg_hit && !upl_done_r;
	wire cfg_rd_ok = cfg_rd && cfg_hit && upl_done_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			ssid_r <= i2c_pkg::SSID_RST;
			cfg_rdata <= '0;
		end else begin
			if (ssid_load) ssid_r <= upl_buf_r;
			// Writable only with the enable set
			else if (cfg_wr && cfg_hit && upl_done_r && subsys_id_write_enable)
				ssid_r <= cfg_wdata;
			cfg_rdata <= cfg_rd_ok ? ssid_r : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	logic [i2c_pkg::QW-1:0] gap_r;
	always_ff @(posedge clk) begin
		if (rst) gap_r <= '0;
		else gap_r <= tick ? '0 : gap_r + 10'h001;
	end

	a_bit_rate: assert property (@(posedge clk) disable iff (rst)
		tick && state_r == i2c_pkg::ST_BIT && q_r != 2'h0 |-> gap_r == qlim - 10'h001)
		else $error("quarter bit period wrong");
	a_start_shape: assert property (@(posedge clk) disable iff (rst)
		state_r == i2c_pkg::ST_START && q_r == 2'h2 && tick |=> !sda_hw_r && scl_hw_r)
		else $error("start condition malformed");
	a_sda_stable_high: assert property (@(posedge clk) disable iff (rst)
		state_r == i2c_pkg::ST_BIT && scl_hw_r && $past(scl_hw_r)
		|-> sda_hw_r == $past(sda_hw_r))
		else $error("SDA moved while SCL high");
	a_stop_shape: assert property (@(posedge clk) disable iff (rst)
		state_r == i2c_pkg::ST_STOP && q_r == 2'h2 && tick |=> sda_hw_r && scl_hw_r)
		else $error("stop condition malformed");
	a_hold_scl_low: assert property (@(posedge clk) disable iff (rst)
		state_r == i2c_pkg::ST_HOLD |-> !scl_hw_r && !busy)
		else $error("SCL released while holding");
	a_done_at_end: assert property (@(posedge clk) disable iff (rst)
		$rose(done_r) |-> state_r == i2c_pkg::ST_IDLE || state_r == i2c_pkg::ST_HOLD)
		else $error("done raised mid transfer");
	a_busy_ignore: assert property (@(posedge clk) disable iff (rst)
		busy && reg_wr && ctrl_hit && !rx_load |=> $stable(b0_r) && $stable(b1_r))
		else $error("write taken while busy");
	a_abort_zero: assert property (@(posedge clk) disable iff (rst)
		kind_r == i2c_pkg::K_UPL && !ack_ok_r && state_r == i2c_pkg::ST_STOP
		&& q_r == 2'h3 && tick |=> ##1 ssid_r == i2c_pkg::SSID_RST && upl_done_r)
		else $error("identity not zero after abort");
	a_retry_gate: assert property (@(posedge clk) disable iff (rst)
		cfg_rd && cfg_hit && !upl_done_r |-> cfg_retry ##1 cfg_rdata == '0)
		else $error("identity read before upload end");
	a_sw_pins: assert property (@(posedge clk) disable iff (rst)
		sw_mode_r |=> scl_oe_n == $past(sw_scl_r) && sda_oe_n == $past(sw_sda_r))
		else $error("software pin control lost");
endmodule

// [hw/quarter_tick.sv]
// Quarter bit period tick generator divided from the system clock.
`timescale 1ns/100ps
module quarter_tick #(
	parameter int W = 10
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] limit,
	output logic tick
);
	logic [W-1:0] cnt_r;
	wire last = (cnt_r >= limit - W'(1));

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= '0;
			tick <= 1'b0;
		end else begin
			cnt_r <= last ? '0 : cnt_r + W'(1);
			tick <= last;
		end
	end
endmodule

// [inc/i2c_pkg.sv]
// Constants, field layout and state types for the serial bus master and ID upload.
package i2c_pkg;
	localparam int CLK_HZ = 250_000_000;
	localparam int SCL_SLOW_HZ = 99_200;
	localparam int SCL_FAST_HZ = 396_800;
	localparam int UPL_HZ = 100_000;
	localparam int QW = 10;
	localparam logic [QW-1:0] Q_SLOW = QW'(CLK_HZ / (4 * SCL_SLOW_HZ));
	localparam logic [QW-1:0] Q_FAST = QW'(CLK_HZ / (4 * SCL_FAST_HZ));
	localparam logic [QW-1:0] Q_UPL = QW'(CLK_HZ / (4 * UPL_HZ));
	localparam logic [11:0] CTRL_OFF = 12'h110;
	localparam logic [7:0] SSID_OFF = 8'h2c;
	localparam int B0_LSB = 24;
	localparam int B1_LSB = 16;
	localparam int B2_LSB = 8;
	localparam int SPEED_BIT = 7;
	localparam int NOSTOP_BIT = 6;
	localparam int NOS1B_BIT = 5;
	localparam int W3BRA_BIT = 4;
	localparam int SWMODE_BIT = 3;
	localparam int ACKOK_BIT = 2;
	localparam int SDA_BIT = 1;
	localparam int SCL_BIT = 0;
	localparam logic [31:0] SSID_RST = 32'h0000_0000;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [6:0] EEPROM_ADDR7 = 7'h50;
	localparam logic [7:0] UPL_LOGICAL = 8'hff;
	localparam logic [7:0] LOGICAL_BIAS = 8'h04;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_BIT = 3'b010,
		ST_STOP = 3'b011,
		ST_HOLD = 3'b100,
		ST_NEXT = 3'b101
	} state_t;
	typedef enum logic [1:0] {
		K_WR = 2'b00,
		K_RD = 2'b01,
		K_CONT = 2'b10,
		K_UPL = 2'b11
	} kind_t;
	typedef enum logic [2:0] {
		OP_START = 3'b000,
		OP_TX = 3'b001,
		OP_RXA = 3'b010,
		OP_RXN = 3'b011,
		OP_END = 3'b100
	} op_t;
endpackage
